/* File: swb_xcvr_ctrl.sv */
`timescale 1ns/10ps
module swb_xcvr_ctrl #(
   parameter int unsigned TOUT_CYC = int'(swb_pkg::TOUT_CYC),
   parameter int unsigned SLEEP_CYC = int'(swb_pkg::SLEEP_CYC)
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic sys_rst,
   // Controller side pins.
   input wire logic txd_pin,
   input wire logic mode_select_first,
   input wire logic mode_select_second,
   output logic rxd_o,
   output logic rxd_oe,
   output logic txd_pullup_en,
   output logic mode_pulldown_en,
   // Analog front end: detector levels in, driver commands out.
   input wire swb_pkg::swb_sense_t sense_in,
   input wire logic overtemp_det,
   input wire logic short_gnd_det,
   output swb_pkg::swb_drive_t bus_line_pin,
   output logic load_gnd_en
);

   // -------------------------------------------------------------------------
   // Pin synchronisation.
   // -------------------------------------------------------------------------
   logic txd_s;                 // Synchronised transmit input.
   logic [1:0] mode_s;          // Synchronised {second, first} selects.
   swb_pkg::swb_sense_t sense_s; // Synchronised detector levels.
   logic [1:0] flt_s;           // Synchronised {overtemp, short}.

   // Every pin passes two flops before any decode or count sees it.
   swb_sync #(.W(1), .RST_VAL(swb_pkg::TXD_RST)) u_sync_txd (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .async_in(txd_pin),
      .sync_out(txd_s)
   );
   swb_sync #(.W(2), .RST_VAL(swb_pkg::MODE_RST)) u_sync_mode (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .async_in({mode_select_second, mode_select_first}),
      .sync_out(mode_s)
   );
   swb_sync #(.W(7), .RST_VAL({swb_pkg::SENSE_RST, 2'h0})) u_sync_sense (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .async_in({sense_in, overtemp_det, short_gnd_det}),
      .sync_out({sense_s, flt_s})
   );

   // -------------------------------------------------------------------------
   // Mode decode.
   // -------------------------------------------------------------------------
   // Map the two selects onto a mode.
   function automatic swb_pkg::swb_mode_t swb_decode(input logic [1:0] sel);
      swb_pkg::swb_mode_t md;
      md = swb_pkg::swb_mode_t'(sel);
      return md;
   endfunction : swb_decode

   swb_pkg::swb_mode_t mode;    // Currently selected mode.
   assign mode = swb_decode(mode_s);

   // The pulls are permanent features of the pads.
   assign txd_pullup_en = 1'b1;
   assign mode_pulldown_en = 1'b1;

   // -------------------------------------------------------------------------
   // Timers.
   // -------------------------------------------------------------------------
   swb_pkg::swb_state_t state_ff; // Operating state.
   logic wake_ok;               // Raised traffic has persisted long enough.
   logic stby_expired;          // Standby has run out without a mode change.
   logic tout_hit;              // Transmit has been low for the timeout.
   logic tout_ff;               // Driver disabled by dominant timeout.

   // Wake filter only listens in sleep, and never under lockout.
   swb_hold_cnt #(.LIMIT(int'(swb_pkg::WUF_CYC))) u_wake_flt (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .run((state_ff == swb_pkg::ST_SLEEP) && sense_s.bus_hv && !sense_s.uvlo),
      .done(wake_ok)
   );

   // Standby counts toward sleep re-entry.
   swb_hold_cnt #(.LIMIT(SLEEP_CYC)) u_sleep_tmo (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .run(state_ff == swb_pkg::ST_STBY),
      .done(stby_expired)
   );

   // Dominant request timing; stops once the guard has tripped.
   swb_hold_cnt #(.LIMIT(TOUT_CYC)) u_dom_tmo (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .run((state_ff == swb_pkg::ST_ACTIVE) && !txd_s && !tout_ff),
      .done(tout_hit)
   );

   // -------------------------------------------------------------------------
   // Operating state.
   // -------------------------------------------------------------------------
   // Power-up lands in standby, which times out to sleep unless the
   // controller selects a mode; the controller then has a full timeout.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= swb_pkg::ST_STBY;
      end else begin
         case (state_ff)
            swb_pkg::ST_SLEEP: begin
               // Either a mode pattern or a filtered bus wake ends sleep.
               if (mode != swb_pkg::MD_SLEEP) begin
                  state_ff <= swb_pkg::ST_ACTIVE;
               end else if (wake_ok) begin
                  state_ff <= swb_pkg::ST_STBY;
               end
            end
            swb_pkg::ST_STBY: begin
               if (mode != swb_pkg::MD_SLEEP) begin
                  state_ff <= swb_pkg::ST_ACTIVE;
               end else if (stby_expired) begin
                  state_ff <= swb_pkg::ST_SLEEP;
               end
            end
            swb_pkg::ST_ACTIVE: begin
               // Selecting the sleep pattern goes straight back to sleep.
               if (mode == swb_pkg::MD_SLEEP) begin
                  state_ff <= swb_pkg::ST_SLEEP;
               end
            end
            default: begin
               state_ff <= swb_pkg::ST_SLEEP;
            end
         endcase
      end
   end

   // Remembers that standby was entered by a bus wake, not power-up.
   logic wake_irq_ff;
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wake_irq_ff <= 1'b0;
      end else if ((state_ff == swb_pkg::ST_SLEEP) && wake_ok &&
                   (mode == swb_pkg::MD_SLEEP)) begin
         wake_irq_ff <= 1'b1;
      end else if (state_ff != swb_pkg::ST_STBY) begin
         wake_irq_ff <= 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // Transmit timeout and receive blanking.
   // -------------------------------------------------------------------------
   logic txd_prev_ff;           // Transmit level one cycle ago.
   logic txd_rise;              // Low-to-high transition of transmit.
   assign txd_rise = txd_s && !txd_prev_ff;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         txd_prev_ff <= swb_pkg::TXD_RST;
      end else begin
         txd_prev_ff <= txd_s;
      end
   end

   // Trip on a stuck dominant request; the next rising edge releases the
   // guard with no delay. Trip and release cannot meet: one needs txd low.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tout_ff <= 1'b0;
      end else if (tout_hit) begin
         tout_ff <= 1'b1;
      end else if (txd_rise) begin
         tout_ff <= 1'b0;
      end
   end

   // Blanking uses the least printed time so no real bit edge is hidden.
   localparam logic [3:0] BLANK_LEN = 4'(swb_pkg::BLANK_CYC);
   logic [3:0] blank_ff;        // Remaining blanking cycles.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         blank_ff <= 4'h0;
      end else if (txd_rise) begin
         blank_ff <= BLANK_LEN;
      end else if (blank_ff != 4'h0) begin
         blank_ff <= blank_ff - 4'h1;
      end
   end

   // -------------------------------------------------------------------------
   // Bus driver commands.
   // -------------------------------------------------------------------------
   swb_pkg::swb_drive_t nxt_drive; // Next driver command.
   always_comb begin
      nxt_drive = '0;
      // Dominant only when active, asked for and not guarded.
      nxt_drive.dom = (state_ff == swb_pkg::ST_ACTIVE) && (mode != swb_pkg::MD_SLEEP) &&
                      !txd_s && !tout_ff && !sense_s.uvlo && !flt_s[1];
      // Raised level only in wake-up mode with full supply.
      nxt_drive.raised = nxt_drive.dom && (mode == swb_pkg::MD_RAISED_VOLTAGE_WAKEUP) && !sense_s.low_supply;
      // Shaping everywhere except high-speed.
      nxt_drive.shape = (mode != swb_pkg::MD_HS);
      // Limit current into a grounded bus; overtemp has already cut dom.
      nxt_drive.ilimit = nxt_drive.dom && flt_s[0];
   end

   // Loss of ground does not gate the driver; it only opens the load ground switch.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bus_line_pin <= '0;
         load_gnd_en <= 1'b1;
      end else begin
         bus_line_pin <= nxt_drive;
         load_gnd_en <= !sense_s.loss_gnd;
      end
   end

   // -------------------------------------------------------------------------
   // Receive output.
   // -------------------------------------------------------------------------
   logic nxt_rxd;               // Next receive level.
   logic nxt_rxd_oe;            // Next receive drive enable.
   always_comb begin
      nxt_rxd = 1'b1;
      nxt_rxd_oe = 1'b1;
      if (sense_s.uvlo) begin
         nxt_rxd_oe = 1'b0;
      end else if (state_ff == swb_pkg::ST_SLEEP) begin
         nxt_rxd_oe = 1'b0;
      end else if (state_ff == swb_pkg::ST_STBY) begin
         // Hold the interrupt low for the whole bus-woken standby.
         nxt_rxd = !wake_irq_ff;
      end else if (blank_ff != 4'h0) begin
         nxt_rxd = 1'b1;
      end else begin
         nxt_rxd = !sense_s.bus_dom;
      end
   end

   // Receive pad is registered so it never glitches on decode changes.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rxd_o <= 1'b1;
         rxd_oe <= 1'b0;
      end else begin
         rxd_o <= nxt_rxd;
         rxd_oe <= nxt_rxd_oe;
      end
   end

   // -------------------------------------------------------------------------
   // Checks.
   // -------------------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   AST_SLEEP_NO_DOM: assert property (
      (state_ff == swb_pkg::ST_SLEEP) |=> !bus_line_pin.dom)
      else $error("Bus driven dominant while asleep.");
   AST_RECESSIVE_TXD: assert property (
      txd_s |=> !bus_line_pin.dom)
      else $error("Bus dominant with transmit high.");
   AST_DOM_DRIVE: assert property (
      ((state_ff == swb_pkg::ST_ACTIVE) && (mode != swb_pkg::MD_SLEEP) && !txd_s &&
       !tout_ff && !sense_s.uvlo && !flt_s[1]) |=> bus_line_pin.dom)
      else $error("Dominant request not driven.");
   AST_TOUT_OFF: assert property (
      tout_hit |=> tout_ff ##1 !bus_line_pin.dom)
      else $error("Driver not switched off after timeout.");
   AST_TOUT_RELEASE: assert property (
      (tout_ff && txd_rise) |=> !tout_ff)
      else $error("Timeout not released on rising transmit.");
   AST_RAISED: assert property (
      sense_s.low_supply |=> !bus_line_pin.raised)
      else $error("Raised level in reduced supply.");
   AST_RXD_SLEEP: assert property (
      (state_ff == swb_pkg::ST_SLEEP) |=> !rxd_oe)
      else $error("Receive driven in sleep.");
   AST_WAKE_IRQ: assert property (
      ((state_ff == swb_pkg::ST_SLEEP) && wake_ok && (mode == swb_pkg::MD_SLEEP))
      |=> (state_ff == swb_pkg::ST_STBY) ##1 (rxd_oe && !rxd_o) || sense_s.uvlo ||
          (state_ff != swb_pkg::ST_STBY))
      else $error("Bus wake gave no receive interrupt.");
   // The first update after the rise still shows the bus as it was while we drove it.
   AST_BLANK: assert property (
      (txd_rise && (state_ff == swb_pkg::ST_ACTIVE) && !sense_s.uvlo) |=> ##1
      ((state_ff != swb_pkg::ST_ACTIVE) || sense_s.uvlo || rxd_o) [*2])
      else $error("Receive not blanked after transmit rise.");
   AST_UVLO: assert property (
      sense_s.uvlo |=> !rxd_oe && !bus_line_pin.dom)
      else $error("Lockout not honoured.");
   AST_SHAPE: assert property (
      (mode == swb_pkg::MD_HS) |=> !bus_line_pin.shape)
      else $error("Shaping left on in high-speed mode.");

   COV_WAKE: cover property ((state_ff == swb_pkg::ST_SLEEP) ##1
                             (state_ff == swb_pkg::ST_STBY));
   COV_TOUT: cover property (tout_hit ##[1:20] txd_rise);
   COV_RAISED_VOLTAGE_WAKEUP_TX: cover property (bus_line_pin.raised);
   COV_STBY_SLEEP: cover property (stby_expired);

endmodule : swb_xcvr_ctrl

/* File: swb_pkg.sv */
// ----------------------------------------------------------------------------
// Shared constants and types of the single-wire bus transceiver control.
// ----------------------------------------------------------------------------
package swb_pkg;

   // -------------------------------------------------------------------------
   // Clock rate.
   // -------------------------------------------------------------------------
   // Core clock rate in hertz, 40 ns period.
   localparam longint unsigned CLK_HZ = 64'd25_000_000;

   // -------------------------------------------------------------------------
   // Printed times and their cycle counts.
   // -------------------------------------------------------------------------
   // Dominant timeout reaction time, typical, in milliseconds.
   localparam longint unsigned TOUT_MS = 64'd17;
   // Typical figure, so it is taken as is (exact at this rate).
   localparam longint unsigned TOUT_CYC = TOUT_MS * CLK_HZ / 64'd1000;
   // Standby to sleep timeout, typical, in milliseconds.
   localparam longint unsigned SLEEP_MS = 64'd250;
   localparam longint unsigned SLEEP_CYC = SLEEP_MS * CLK_HZ / 64'd1000;
   // Least wake-up filter delay in microseconds; rounded up to cycles.
   localparam longint unsigned WUF_MIN_US = 64'd10;
   localparam longint unsigned WUF_CYC = (WUF_MIN_US * CLK_HZ + 64'd999_999) / 64'd1_000_000;
   // Least receive blanking time in nanoseconds; rounded up to cycles.
   localparam longint unsigned BLANK_MIN_NS = 64'd500;
   localparam longint unsigned BLANK_CYC =
      (BLANK_MIN_NS * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000;

   // -------------------------------------------------------------------------
   // Reset values of the synchronised pins.
   // -------------------------------------------------------------------------
   // Transmit input idles high (recessive), mode inputs idle low (sleep).
   localparam logic TXD_RST = 1'b1;
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [4:0] SENSE_RST = 5'h00;

   // -------------------------------------------------------------------------
   // Modes and states.
   // -------------------------------------------------------------------------
   // Mode code is {second select, first select}.
   typedef enum logic [1:0] {
      MD_SLEEP = 2'b00,
      MD_HS    = 2'b01,
      MD_RAISED_VOLTAGE_WAKEUP  = 2'b10,
      MD_NORM  = 2'b11
   } swb_mode_t;

   // Operating state of the transceiver.
   typedef enum logic [1:0] {
      ST_SLEEP  = 2'b00,
      ST_STBY   = 2'b01,
      ST_ACTIVE = 2'b10
   } swb_state_t;

   // Analog detector levels coming into the logic.
   typedef struct packed {
      logic bus_dom;   // Bus above the dominant receive threshold.
      logic bus_hv;    // Bus above the raised wake-up threshold.
      logic uvlo;      // Supply below the lockout threshold.
      logic low_supply; // Supply in the reduced band.
      logic loss_gnd;  // Valid loss-of-ground condition.
   } swb_sense_t;

   // Commands to the analog bus driver.
   typedef struct packed {
      logic dom;       // Drive the bus line dominant.
      logic raised;    // Use the raised wake-up dominant level.
      logic shape;     // Edge wave shaping on.
      logic ilimit;    // Short-circuit current limit engaged.
   } swb_drive_t;

endpackage : swb_pkg

/* File: swb_sync.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Two flip-flop synchroniser for asynchronous levels.
// ----------------------------------------------------------------------------
module swb_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic sys_rst,
   // Asynchronous level in, synchronised level out.
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   // First stage; only the second stage reads it.
   logic [W-1:0] meta_ff;

   // Both stages reset to the idle level of the pin.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_ff <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta_ff <= async_in;
         sync_out <= meta_ff;
      end
   end

endmodule : swb_sync

/* File: swb_hold_cnt.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Persistence counter: done rises once run has held for LIMIT cycles.
// ----------------------------------------------------------------------------
module swb_hold_cnt #(
   parameter int unsigned LIMIT = 250
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic sys_rst,
   // Condition to time, and its expiry flag.
   input wire logic run,
   output logic done
);

   localparam int CW = $clog2(LIMIT + 1);
   localparam logic [CW-1:0] LIM = CW'(LIMIT);

   // Cycles that run has held; clears the moment run drops.
   logic [CW-1:0] cnt_ff;

   // Saturating count so done stays up while run holds.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_ff <= '0;
      end else if (!run) begin
         cnt_ff <= '0;
      end else if (cnt_ff != LIM) begin
         cnt_ff <= cnt_ff + CW'(1);
      end
   end

   // Expiry is the register compare, gated by run.
   assign done = run && (cnt_ff == LIM);

endmodule : swb_hold_cnt

/* File: swb_ctl_model.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Behavioural protocol controller that drives transmit and the mode selects.
// ----------------------------------------------------------------------------
module swb_ctl_model (
   // Clock and the receive pin as the controller sees it.
   input wire logic core_clk,
   input wire logic rxd_o,
   input wire logic rxd_oe,
   // Pins driven toward the transceiver.
   output logic txd_pin,
   output logic mode_select_first,
   output logic mode_select_second
);
   // When set, a wake interrupt is answered by selecting normal mode.
   logic auto_answer = 1'b0;

   // Idle pins: recessive transmit, sleep pattern on the selects.
   initial begin
      txd_pin = 1'b1;
      mode_select_first = 1'b0;
      mode_select_second = 1'b0;
   end

   // Changes land just after an edge so the sampling edge never races them.
   task set_mode(input logic [1:0] m);
      @(posedge core_clk);
      #1;
      mode_select_first = m[0];
      mode_select_second = m[1];
   endtask : set_mode

   task set_txd(input logic v);
      @(posedge core_clk);
      #1;
      txd_pin = v;
   endtask : set_txd

   // A real controller must answer inside the sleep timeout; this one does it at once.
   always @(posedge core_clk) begin
      if (auto_answer && rxd_oe === 1'b1 && rxd_o === 1'b0) begin
         #1;
         mode_select_first = 1'b1;
         mode_select_second = 1'b1;
      end
   end
endmodule : swb_ctl_model

/* File: swb_xcvr_ctrl_tb_top.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Self-checking bench; short timeout counts keep the run brief.
// ----------------------------------------------------------------------------
module swb_xcvr_ctrl_tb_top;
   localparam int TOUT = 40; // Shortened dominant timeout.
   localparam int SLP = 60; // Shortened standby to sleep timeout.
   localparam int WUF = 250; // Wake filter length after synchronising.
   logic core_clk;
   logic sys_rst;
   logic overtemp_det;
   logic short_gnd_det;
   swb_pkg::swb_sense_t sense; // Analog detector levels.
   swb_pkg::swb_drive_t drv; // Driver commands seen.
   wire logic txd_pin;
   wire logic msel_a;
   wire logic msel_b;
   logic rxd_o, rxd_oe, pu_en, pd_en, load_gnd_en;
   int n_fail = 0;
   int check_count = 0;
   int cyc = 0;

   // Clock at 25 MHz.
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   swb_xcvr_ctrl #(.TOUT_CYC(TOUT), .SLEEP_CYC(SLP)) uut (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .txd_pin(txd_pin),
      .mode_select_first(msel_a),
      .mode_select_second(msel_b),
      .rxd_o(rxd_o),
      .rxd_oe(rxd_oe),
      .txd_pullup_en(pu_en),
      .mode_pulldown_en(pd_en),
      .sense_in(sense),
      .overtemp_det(overtemp_det),
      .short_gnd_det(short_gnd_det),
      .bus_line_pin(drv),
      .load_gnd_en(load_gnd_en)
   );

   swb_ctl_model ctl (
      .core_clk(core_clk),
      .rxd_o(rxd_o),
      .rxd_oe(rxd_oe),
      .txd_pin(txd_pin),
      .mode_select_first(msel_a),
      .mode_select_second(msel_b)
   );

   // ------------------------------------------------------------------------
   // Helpers.
   // ------------------------------------------------------------------------
   // Ends just after an edge, where inputs change and outputs are settled.
   task tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   task chk(input string nm, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %b seen %b", nm, e, g);
      end
   endtask : chk

   task test_done;
      if (n_fail == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done

   // A hang is cut short well beyond the thousand or so cycles the run needs.
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         test_done();
      end
   end

   // ------------------------------------------------------------------------
   // Scenarios.
   // ------------------------------------------------------------------------
   task t_reset;
      tick(3);
      chk("rst rxd_oe", 1'b0, rxd_oe);
      chk("rst dom", 1'b0, drv.dom);
      chk("rst load", 1'b1, load_gnd_en);
      chk("pullup", 1'b1, pu_en);
      chk("pulldown", 1'b1, pd_en);
      tick(1);
      sys_rst = 1'b0;
      tick(2);
      chk("pwrup oe", 1'b1, rxd_oe);
      chk("pwrup no irq", 1'b1, rxd_o);
   endtask : t_reset

   // Every active code: dominant level, raised level and shaping per mode.
   task t_modes;
      for (int m = 1; m < 4; m++) begin
         ctl.set_mode(m[1:0]);
         ctl.set_txd(1'b0);
         tick(5);
         chk("dom", 1'b1, drv.dom);
         chk("raised", m == 2, drv.raised);
         chk("shape", m != 1, drv.shape);
         ctl.set_txd(1'b1);
         tick(5);
         chk("recessive", 1'b0, drv.dom);
      end
   endtask : t_modes

   // Forwarding, and blanking after a transmit rising edge.
   task t_receive;
      sense.bus_dom = 1'b1;
      // Wait out the blanking left by the last rise of the mode loop.
      tick(14);
      chk("rx dom", 1'b0, rxd_o);
      ctl.set_txd(1'b0);
      tick(4);
      ctl.set_txd(1'b1);
      tick(4);
      chk("rx blank", 1'b1, rxd_o);
      tick(14);
      chk("rx after blank", 1'b0, rxd_o);
      sense.bus_dom = 1'b0;
      tick(5);
      chk("rx rec", 1'b1, rxd_o);
   endtask : t_receive

   task t_timeout;
      ctl.set_txd(1'b0);
      tick(TOUT - 5);
      chk("before tout", 1'b1, drv.dom);
      tick(10);
      chk("tout", 1'b0, drv.dom);
      ctl.set_txd(1'b1);
      tick(3);
      ctl.set_txd(1'b0);
      tick(5);
      chk("resume", 1'b1, drv.dom);
      ctl.set_txd(1'b1);
      tick(20);
   endtask : t_timeout

   // Supply and fault reactions in wake-up mode with transmit held low.
   task t_faults;
      ctl.set_mode(2'h2);
      ctl.set_txd(1'b0);
      sense.low_supply = 1'b1;
      tick(4);
      chk("low raised", 1'b0, drv.raised);
      sense.loss_gnd = 1'b1;
      tick(4);
      chk("load open", 1'b0, load_gnd_en);
      chk("lgnd dom", 1'b1, drv.dom);
      short_gnd_det = 1'b1;
      tick(4);
      chk("ilimit", 1'b1, drv.ilimit);
      overtemp_det = 1'b1;
      tick(4);
      chk("otemp dom", 1'b0, drv.dom);
      sense = '0;
      sense.uvlo = 1'b1;
      overtemp_det = 1'b0;
      short_gnd_det = 1'b0;
      tick(4);
      chk("uvlo dom", 1'b0, drv.dom);
      chk("uvlo oe", 1'b0, rxd_oe);
      chk("uvlo rx", 1'b1, rxd_o);
      ctl.set_txd(1'b1);
      sense = '0;
      tick(20);
   endtask : t_faults

   // Sleep, filtered wake, timeout back to sleep, then an answered wake.
   task t_sleep;
      ctl.set_mode(2'h0);
      ctl.set_txd(1'b0);
      tick(5);
      chk("sleep oe", 1'b0, rxd_oe);
      chk("sleep dom", 1'b0, drv.dom);
      ctl.set_txd(1'b1);
      sense.bus_hv = 1'b1;
      tick(WUF - 100);
      sense.bus_hv = 1'b0;
      tick(5);
      chk("short hv", 1'b0, rxd_oe);
      sense.bus_hv = 1'b1;
      tick(WUF + 6);
      chk("wake oe", 1'b1, rxd_oe);
      chk("wake irq", 1'b0, rxd_o);
      sense.bus_hv = 1'b0;
      tick(SLP + 5);
      chk("resleep", 1'b0, rxd_oe);
      ctl.auto_answer = 1'b1;
      sense.bus_hv = 1'b1;
      tick(WUF + 6);
      sense.bus_hv = 1'b0;
      ctl.auto_answer = 1'b0;
      tick(SLP + 10);
      chk("answered oe", 1'b1, rxd_oe);
      chk("answered rx", 1'b1, rxd_o);
   endtask : t_sleep

   initial begin
      sys_rst = 1'b1;
      overtemp_det = 1'b0;
      short_gnd_det = 1'b0;
      sense = '0;
      t_reset();
      t_modes();
      t_receive();
      t_timeout();
      t_faults();
      t_sleep();
      test_done();
   end
endmodule : swb_xcvr_ctrl_tb_top
